// >>> mum_defines.vh
`ifndef MUM_DEFINES_VH
`define MUM_DEFINES_VH

// ==========================================================================
// Word addresses of the monitor bank in unit memory.
`define MUM_ADDR_SYSTEM_FAULT   16'h1770
`define MUM_ADDR_TASK1_FAULT    16'h1771
`define MUM_ADDR_TASK2_FAULT    16'h1772
`define MUM_ADDR_TASK3_FAULT    16'h1773
`define MUM_ADDR_TASK4_FAULT    16'h1774
`define MUM_ADDR_AXIS_X_FAULT   16'h1775
`define MUM_ADDR_AXIS_Y_FAULT   16'h1776
`define MUM_ADDR_AXIS_Z_FAULT   16'h1777
`define MUM_ADDR_AXIS_U_FAULT   16'h1778
`define MUM_ADDR_XY_PIN_STATUS  16'h177B
`define MUM_ADDR_ZU_PIN_STATUS  16'h177C
`define MUM_ADDR_TASK1_PROGRAM  16'h1784

// ==========================================================================
// Axis status image field positions.
`define MUM_BIT_GP_INPUT        0
`define MUM_BIT_GP_OUTPUT       1
`define MUM_BIT_CCW_LIMIT       8
`define MUM_BIT_CW_LIMIT        9
`define MUM_BIT_ORIGIN          10
`define MUM_BIT_ESTOP           11
`define MUM_BIT_DRV_ALARM       12
`define MUM_BIT_RUN_CMD         13
`define MUM_BIT_ALARM_RESET     14
`define MUM_BIT_SENSOR_ON       15

// ==========================================================================
// Reset values and limits.
`define MUM_RESET_WORD          16'h0000
`define MUM_PROGRAM_MAX         10'h3E7
`define MUM_UNMAPPED_WORD       16'h0000

`endif

// >>> mum_sync2.v
`timescale 1ns/10ps
module mum_sync2 #(
	parameter WIDTH = 8
) (
	input  wire             clock,
	input  wire             rst,
	input  wire [WIDTH-1:0] async_in,
	output reg  [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] meta_reg;

	// ======================================================================
	// Two-stage synchroniser; the first stage feeds only the second.
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			meta_reg <= {WIDTH{1'b0}};
			sync_out <= {WIDTH{1'b0}};
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule // mum_sync2

// >>> mum_axis_image.v
`timescale 1ns/10ps
`include "mum_defines.vh"
module mum_axis_image (
	input  wire        clock,
	input  wire        rst,
	input  wire        gp_input,
	input  wire        gp_output,
	input  wire        ccw_limit,
	input  wire        cw_limit,
	input  wire        origin_prox,
	input  wire        estop,
	input  wire        drv_alarm,
	input  wire        run_cmd,
	input  wire        alarm_reset,
	input  wire        sensor_on,
	output reg  [15:0] image
);

	reg [15:0] image_next;

	// ======================================================================
	// Packs one axis's pin levels; bits 2 to 7 stay zero.
	always @* begin
		image_next                       = `MUM_RESET_WORD;
		image_next[`MUM_BIT_GP_INPUT]    = gp_input;
		image_next[`MUM_BIT_GP_OUTPUT]   = gp_output;
		image_next[`MUM_BIT_CCW_LIMIT]   = ccw_limit;
		image_next[`MUM_BIT_CW_LIMIT]    = cw_limit;
		image_next[`MUM_BIT_ORIGIN]      = origin_prox;
		image_next[`MUM_BIT_ESTOP]       = estop;
		image_next[`MUM_BIT_DRV_ALARM]   = drv_alarm;
		image_next[`MUM_BIT_RUN_CMD]     = run_cmd;
		image_next[`MUM_BIT_ALARM_RESET] = alarm_reset;
		image_next[`MUM_BIT_SENSOR_ON]   = sensor_on;
	end

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			image <= `MUM_RESET_WORD;
		end else begin
			image <= image_next;
		end
	end

endmodule // mum_axis_image

// >>> mum_monitor_bank.v
`timescale 1ns/10ps
`include "mum_defines.vh"
// Overview of operation
// - Every monitor word is read-only; host writes are accepted and leave all contents unchanged.
// - With four axes off, tasks 3 and 4, axes Z and U and the Z/U status word are absent and read zero.
// - The system fault word holds the unit's error code and reads zero when all is normal.
// - Tasks 1 to 4 report their error codes in consecutive words of one common layout.
// - Axes X, Y, Z and U report error codes in their own words, zero when the axis is healthy.
// - The X/Y status word carries only the 16-bit X image, bits 2 to 7 always zero; the Y image cannot be read.
// - Bits 0 and 1 of an image are the axis's general-purpose input and output.
// - Bits 8, 9 and 10 mirror the counterclockwise limit, clockwise limit and origin proximity inputs.
// - Bits 11 and 12 mirror the emergency stop and servo driver alarm inputs.
// - Bits 13, 14 and 15 show the run command, alarm reset and sensor-on outputs as driven.
// - The four-axis build adds a Z/U status word of the same layout that carries only the Z image; the U image cannot be read.
// - The task 1 program word holds the running or last run program number, 000 to 3E7 hex.
module mum_monitor_bank #(
	parameter FOUR_AXIS = 1
) (
	input  wire        clock,
	input  wire        rst,
	// Host side: unit memory read and write commands.
	input  wire        unit_memory_read_command,
	input  wire        unit_memory_write_command,
	input  wire [15:0] mem_addr,
	input  wire [15:0] mem_wdata,
	output reg  [15:0] mem_rdata,
	output reg         mem_rvalid,
	output reg         mem_wack,
	output reg         mem_hit,
	// Internal unit state, same clock domain.
	input  wire [15:0] system_fault_in,
	input  wire [15:0] task1_fault_in,
	input  wire [15:0] task2_fault_in,
	input  wire [15:0] task3_fault_in,
	input  wire [15:0] task4_fault_in,
	input  wire [15:0] axis_x_fault_in,
	input  wire [15:0] axis_y_fault_in,
	input  wire [15:0] axis_z_fault_in,
	input  wire [15:0] axis_u_fault_in,
	input  wire [9:0]  task1_program_in,
	// Unit-driven outputs, same clock domain, one bit per axis X,Y,Z,U.
	input  wire [3:0]  gp_output_in,
	input  wire [3:0]  run_cmd_in,
	input  wire [3:0]  alarm_reset_in,
	input  wire [3:0]  sensor_on_in,
	// Field pins, asynchronous, one bit per axis X,Y,Z,U.
	input  wire [3:0]  gp_input_pin,
	input  wire [3:0]  counterclockwise_limit_pin,
	input  wire [3:0]  clockwise_limit_pin,
	input  wire [3:0]  origin_prox_pin,
	input  wire [3:0]  estop_pin,
	input  wire [3:0]  drv_alarm_pin
);

	// ======================================================================
	// Pin synchronisation.
	wire [23:0] pins_async;
	wire [23:0] pins_sync;

	assign pins_async = {gp_input_pin, counterclockwise_limit_pin, clockwise_limit_pin,
	                     origin_prox_pin, estop_pin, drv_alarm_pin};

	mum_sync2 #(
		.WIDTH    (24)
	) u_pin_sync (
		.clock    (clock),
		.rst      (rst),
		.async_in (pins_async),
		.sync_out (pins_sync)
	);

	wire [3:0] gpi_s;
	wire [3:0] ccw_s;
	wire [3:0] cw_s;
	wire [3:0] org_s;
	wire [3:0] estop_s;
	wire [3:0] alarm_s;

	assign gpi_s   = pins_sync[23:20];
	assign ccw_s   = pins_sync[19:16];
	assign cw_s    = pins_sync[15:12];
	assign org_s   = pins_sync[11:8];
	assign estop_s = pins_sync[7:4];
	assign alarm_s = pins_sync[3:0];

	// ======================================================================
	// Per-axis status images.
	wire [15:0] image_w [0:3];

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_axis
			mum_axis_image u_image (
				.clock       (clock),
				.rst         (rst),
				.gp_input    (gpi_s[gi]),
				.gp_output   (gp_output_in[gi]),
				.ccw_limit   (ccw_s[gi]),
				.cw_limit    (cw_s[gi]),
				.origin_prox (org_s[gi]),
				.estop       (estop_s[gi]),
				.drv_alarm   (alarm_s[gi]),
				.run_cmd     (run_cmd_in[gi]),
				.alarm_reset (alarm_reset_in[gi]),
				.sensor_on   (sensor_on_in[gi]),
				.image       (image_w[gi])
			);
		end
	endgenerate

	// ======================================================================
	// Monitor words, refreshed every cycle from unit state only.
	reg [15:0] system_fault_reg;
	reg [15:0] task1_fault_reg;
	reg [15:0] task2_fault_reg;
	reg [15:0] task3_fault_reg;
	reg [15:0] task4_fault_reg;
	reg [15:0] axis_x_fault_reg;
	reg [15:0] axis_y_fault_reg;
	reg [15:0] axis_z_fault_reg;
	reg [15:0] axis_u_fault_reg;
	reg [9:0]  task1_program_reg;
	reg [9:0]  task1_program_next;

	// An out-of-range program number keeps the last legal one.
	always @* begin
		if (task1_program_in > `MUM_PROGRAM_MAX) begin
			task1_program_next = task1_program_reg;
		end else begin
			task1_program_next = task1_program_in;
		end
	end

	// Only internal state loads these; the host write path has no way in.
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			system_fault_reg <= `MUM_RESET_WORD;
		end else begin
			system_fault_reg <= system_fault_in;
		end
	end

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			task1_fault_reg <= `MUM_RESET_WORD;
		end else begin
			task1_fault_reg <= task1_fault_in;
		end
	end

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			task2_fault_reg <= `MUM_RESET_WORD;
		end else begin
			task2_fault_reg <= task2_fault_in;
		end
	end

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			task3_fault_reg <= `MUM_RESET_WORD;
		end else begin
			task3_fault_reg <= task3_fault_in;
		end
	end

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			task4_fault_reg <= `MUM_RESET_WORD;
		end else begin
			task4_fault_reg <= task4_fault_in;
		end
	end

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			axis_x_fault_reg <= `MUM_RESET_WORD;
		end else begin
			axis_x_fault_reg <= axis_x_fault_in;
		end
	end

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			axis_y_fault_reg <= `MUM_RESET_WORD;
		end else begin
			axis_y_fault_reg <= axis_y_fault_in;
		end
	end

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			axis_z_fault_reg <= `MUM_RESET_WORD;
		end else begin
			axis_z_fault_reg <= axis_z_fault_in;
		end
	end

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			axis_u_fault_reg <= `MUM_RESET_WORD;
		end else begin
			axis_u_fault_reg <= axis_u_fault_in;
		end
	end

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			task1_program_reg <= 10'h000;
		end else begin
			task1_program_reg <= task1_program_next;
		end
	end

	// ======================================================================
	// Read decode.
	wire four_axis;

	assign four_axis = (FOUR_AXIS != 0);

	reg [15:0] rdata_next;
	reg        hit_next;

	// Absent words of the two-axis build read zero and report no hit.
	always @* begin
		rdata_next = `MUM_UNMAPPED_WORD;
		hit_next   = 1'b1;
		case (mem_addr)
			`MUM_ADDR_SYSTEM_FAULT: begin
				rdata_next = system_fault_reg;
			end
			`MUM_ADDR_TASK1_FAULT: begin
				rdata_next = task1_fault_reg;
			end
			`MUM_ADDR_TASK2_FAULT: begin
				rdata_next = task2_fault_reg;
			end
			`MUM_ADDR_TASK3_FAULT: begin
				if (four_axis) begin
					rdata_next = task3_fault_reg;
				end else begin
					rdata_next = `MUM_UNMAPPED_WORD;
					hit_next   = 1'b0;
				end
			end
			`MUM_ADDR_TASK4_FAULT: begin
				if (four_axis) begin
					rdata_next = task4_fault_reg;
				end else begin
					rdata_next = `MUM_UNMAPPED_WORD;
					hit_next   = 1'b0;
				end
			end
			`MUM_ADDR_AXIS_X_FAULT: begin
				rdata_next = axis_x_fault_reg;
			end
			`MUM_ADDR_AXIS_Y_FAULT: begin
				rdata_next = axis_y_fault_reg;
			end
			`MUM_ADDR_AXIS_Z_FAULT: begin
				if (four_axis) begin
					rdata_next = axis_z_fault_reg;
				end else begin
					rdata_next = `MUM_UNMAPPED_WORD;
					hit_next   = 1'b0;
				end
			end
			`MUM_ADDR_AXIS_U_FAULT: begin
				if (four_axis) begin
					rdata_next = axis_u_fault_reg;
				end else begin
					rdata_next = `MUM_UNMAPPED_WORD;
					hit_next   = 1'b0;
				end
			end
			`MUM_ADDR_XY_PIN_STATUS: begin
				rdata_next = image_w[0];
			end
			`MUM_ADDR_ZU_PIN_STATUS: begin
				if (four_axis) begin
					rdata_next = image_w[2];
				end else begin
					rdata_next = `MUM_UNMAPPED_WORD;
					hit_next   = 1'b0;
				end
			end
			`MUM_ADDR_TASK1_PROGRAM: begin
				rdata_next = {6'h00, task1_program_reg};
			end
			default: begin
				hit_next = 1'b0;
			end
		endcase
	end

	// ======================================================================
	// Host answer registers. Reads touch only these, never the monitor words.
	// A write raises its acknowledge and updates mem_hit; read data keep the last read.
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			mem_rvalid <= 1'b0;
		end else begin
			mem_rvalid <= unit_memory_read_command;
		end
	end

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			mem_wack <= 1'b0;
		end else begin
			mem_wack <= unit_memory_write_command;
		end
	end

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			mem_rdata <= `MUM_UNMAPPED_WORD;
		end else if (unit_memory_read_command) begin
			mem_rdata <= rdata_next;
		end
	end

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			mem_hit <= 1'b0;
		end else if (unit_memory_read_command || unit_memory_write_command) begin
			mem_hit <= hit_next;
		end
	end

	// ======================================================================
	// Inputs that no monitor word uses.
	// The status words are 16 bits wide, so only the lower-word image of
	// each pair (X at 177B, Z at 177C) is offered; the Y and U images are
	// built but cannot be reached through this port.
	wire unused_wdata;
	wire unused_upper_images;

	assign unused_wdata        = ^mem_wdata;
	assign unused_upper_images = ^{image_w[1], image_w[3]};

endmodule // mum_monitor_bank

// >>> mum_monitor_asserts.sv
`timescale 1ns/10ps
// ==========================================
// Port checker for the monitor bank.
module mum_monitor_asserts #(
	parameter FOUR_AXIS = 1
) (
	input logic        clock,
	input logic        rst,
	input logic        unit_memory_read_command,
	input logic        unit_memory_write_command,
	input logic [15:0] mem_addr,
	input logic [15:0] mem_rdata,
	input logic        mem_rvalid,
	input logic        mem_wack,
	input logic        mem_hit,
	input logic [15:0] system_fault_in,
	input logic [15:0] task1_fault_in,
	input logic [15:0] axis_x_fault_in,
	input logic [15:0] axis_y_fault_in
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	wire rd = unit_memory_read_command;
	chk_system_fault_word: assert property (
		rd && mem_addr == 16'h1770 && $stable(system_fault_in) && !$past(rst)
		|=> mem_rdata == $past(system_fault_in) && mem_hit) else $error("system fault word");
	chk_task_fault_word: assert property (
		rd && mem_addr == 16'h1771 && $stable(task1_fault_in) && !$past(rst)
		|=> mem_rdata == $past(task1_fault_in)) else $error("task fault word");
	chk_axis_fault_word: assert property (
		rd && mem_addr == 16'h1776 && $stable(axis_y_fault_in) && !$past(rst)
		|=> mem_rdata == $past(axis_y_fault_in)) else $error("axis fault word");
	chk_absent_words_zero: assert property (
		FOUR_AXIS == 0 && rd && mem_addr inside {16'h1773, 16'h1774, 16'h1777, 16'h1778, 16'h177C}
		|=> mem_rdata == 16'h0000 && !mem_hit) else $error("absent word not zero");
	chk_image_unused_bits: assert property (
		rd && mem_addr == 16'h177B |=> mem_rvalid && mem_rdata[7:2] == 6'h00) else $error("unused bits set");
	chk_program_range: assert property (
		rd && mem_addr == 16'h1784 |=> mem_rdata <= 16'h03E7) else $error("program number range");
	chk_write_no_change: assert property (
		unit_memory_write_command && !rd |=> mem_wack && $stable(mem_rdata)) else $error("write effect");
	chk_reread_same: assert property (
		rd && mem_addr == 16'h1775 && $stable(axis_x_fault_in) ##1 $stable(axis_x_fault_in)
		##1 rd && mem_addr == 16'h1775 && $stable(axis_x_fault_in)
		|=> mem_rdata == $past(mem_rdata, 2)) else $error("reread differs");
endmodule // mum_monitor_asserts

bind mum_monitor_bank mum_monitor_asserts #(.FOUR_AXIS(FOUR_AXIS)) i_chk (.*);

// >>> mum_host_model.sv
`timescale 1ns/10ps
// ==========================================
// Host controller reaching unit memory one word at a time.
module mum_host_model (
	input  logic        clock,
	output logic        unit_memory_read_command,
	output logic        unit_memory_write_command,
	output logic [15:0] mem_addr,
	output logic [15:0] mem_wdata,
	input  logic [15:0] mem_rdata,
	input  logic        mem_rvalid,
	input  logic        mem_wack
);
	initial begin
		unit_memory_read_command = 0;
		unit_memory_write_command = 0;
		mem_addr = 16'h0000;
		mem_wdata = 16'h0000;
	end
	// The idle bus carries inverted values so a stale address can never pass for a live one.
	task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic ok);
		@(negedge clock);
		unit_memory_read_command = 1;
		mem_addr = a;
		@(negedge clock);
		unit_memory_read_command = 0;
		mem_addr = ~a;
		d = mem_rdata;
		ok = mem_rvalid;
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] w, output logic ok);
		@(negedge clock);
		unit_memory_write_command = 1;
		mem_addr = a;
		mem_wdata = w;
		@(negedge clock);
		unit_memory_write_command = 0;
		mem_addr = ~a;
		mem_wdata = ~w;
		ok = mem_wack;
	endtask
endmodule // mum_host_model

// >>> motion_unit_monitor_registers_tb_top.sv
`timescale 1ns/10ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin err_count++; \
	$display("wrong value %s expected %h seen %h", n, e, s); end end
module motion_unit_monitor_registers_tb_top;
	logic        clock = 0;
	logic        rst = 1;
	logic [15:0] flt [9];
	wire  [15:0] system_fault_in = flt[0], task1_fault_in = flt[1], task2_fault_in = flt[2],
		task3_fault_in = flt[3], task4_fault_in = flt[4], axis_x_fault_in = flt[5],
		axis_y_fault_in = flt[6], axis_z_fault_in = flt[7], axis_u_fault_in = flt[8];
	logic [9:0]  task1_program_in;
	logic [3:0]  gp_output_in, run_cmd_in, alarm_reset_in, sensor_on_in, gp_input_pin, estop_pin;
	logic [3:0]  counterclockwise_limit_pin, clockwise_limit_pin, origin_prox_pin, drv_alarm_pin;
	wire         unit_memory_read_command, unit_memory_write_command, mem_rvalid, mem_wack, mem_hit;
	wire  [15:0] mem_addr, mem_wdata, mem_rdata, rd2;
	logic [15:0] d;
	logic        ok;
	int          err_count, total_checks, last_prog, seed;
	logic [15:0] addrs [14] = '{16'h1770, 16'h1771, 16'h1772, 16'h1773, 16'h1774, 16'h1775, 16'h1776,
		16'h1777, 16'h1778, 16'h177B, 16'h177C, 16'h1784, 16'h1779, 16'h1785};

	mum_host_model i_host (.*);
	mum_monitor_bank #(.FOUR_AXIS(1)) i_dut (.*);
	mum_monitor_bank #(.FOUR_AXIS(0)) i_dut2 (.*, .mem_rdata(rd2), .mem_rvalid(), .mem_wack(), .mem_hit());

	always #12.5 clock = ~clock;

	function automatic logic [15:0] img(input int x);
		return {sensor_on_in[x], alarm_reset_in[x], run_cmd_in[x], drv_alarm_pin[x], estop_pin[x],
			origin_prox_pin[x], clockwise_limit_pin[x], counterclockwise_limit_pin[x], 6'h00,
			gp_output_in[x], gp_input_pin[x]};
	endfunction

	function automatic logic [15:0] exp_word(input logic [15:0] a, input bit f);
		int i;
		i = a - 16'h1770;
		if (i >= 0 && i <= 8)
			return (f || !(i inside {3, 4, 7, 8})) ? flt[i] : 16'h0000;
		if (a == 16'h177B)
			return img(0);
		if (a == 16'h177C && f)
			return img(2);
		if (a == 16'h1784)
			return 16'(last_prog);
		return 16'h0000;
	endfunction

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		#(25 * 4000);
		err_count++;
		print_verdict();
	end

	initial begin
		seed = $urandom(65);
		flt = '{default: 16'h0000};
		{gp_output_in, run_cmd_in, alarm_reset_in, sensor_on_in, gp_input_pin, estop_pin} = '0;
		{counterclockwise_limit_pin, clockwise_limit_pin, origin_prox_pin, drv_alarm_pin} = '0;
		task1_program_in = 10'h000;
		repeat (2) @(posedge clock);
		@(negedge clock) rst = 0;
		for (int it = 0; it < 6; it++) begin
			@(negedge clock);
			// Pass 1 is the healthy unit, pass 2 offers an out-of-range program number.
			foreach (flt[k]) flt[k] = (it == 1) ? 16'h0000 : 16'($urandom);
			{gp_output_in, run_cmd_in, alarm_reset_in, sensor_on_in, gp_input_pin, estop_pin} = 24'($urandom);
			{counterclockwise_limit_pin, clockwise_limit_pin, origin_prox_pin, drv_alarm_pin} = 16'($urandom);
			task1_program_in = (it == 2) ? 10'h3FF : 10'($urandom_range(999));
			if (task1_program_in <= 10'h3E7)
				last_prog = task1_program_in;
			repeat (4) @(posedge clock);
			foreach (addrs[j]) begin
				i_host.wr(addrs[j], 16'($urandom), ok);
				`CHK("write ack", 1'b1, ok)
			end
			foreach (addrs[j]) repeat (2) begin
				i_host.rd(addrs[j], d, ok);
				`CHK("read valid", 1'b1, ok)
				`CHK("address hit", (j < 12), mem_hit)
				`CHK("four-axis word", exp_word(addrs[j], 1), d)
				`CHK("two-axis word", exp_word(addrs[j], 0), rd2)
			end
			$display("test %0d done", it);
		end
		print_verdict();
	end
endmodule // motion_unit_monitor_registers_tb_top
